// File: pkg/spmz_consts.svh
`ifndef SPMZ_CONSTS_SVH
`define SPMZ_CONSTS_SVH

// Register word indices; byte address is four times the index
`define SPMZ_IDX_RATE_CTRL 8'h87
`define SPMZ_IDX_SER_CTRL 8'h98
`define SPMZ_IDX_SER_BUF 8'h99

// Rate control fields
`define SPMZ_BIT_BAUD_DOUBLE 7
`define SPMZ_BIT_FRAME_ERR_SEL 6

// Serial control fields
`define SPMZ_BIT_MODE_HI 7
`define SPMZ_BIT_MODE_LO 6
`define SPMZ_BIT_MP_RATE 5
`define SPMZ_BIT_RX_EN 4
`define SPMZ_BIT_TX_NINTH 3
`define SPMZ_BIT_RX_NINTH 2
`define SPMZ_BIT_TX_DONE 1
`define SPMZ_BIT_RX_DONE 0

// Reset values
`define SPMZ_RST_BYTE 8'h00

// Timing
`define SPMZ_SYS_CLK_HZ 50000000
`define SPMZ_M0_DIV_SLOW 12
`define SPMZ_M0_DIV_FAST 4
`define SPMZ_M2_DIV 64
`define SPMZ_OVERSAMPLE 16
`define SPMZ_MID_TICK 7
`define SPMZ_LAST_TICK 15

`endif

// File: pkg/spmz_pkg.sv
package spmz_pkg;

  typedef enum logic [2:0] {
    M0_IDLE = 3'b001,
    M0_TX = 3'b010,
    M0_RX = 3'b100
  } spmz_m0_state_type;

  typedef enum logic [1:0] {
    ATX_IDLE = 2'b01,
    ATX_SEND = 2'b10
  } spmz_atx_state_type;

  typedef enum logic [2:0] {
    ARX_IDLE = 3'b001,
    ARX_START = 3'b010,
    ARX_BITS = 3'b100
  } spmz_arx_state_type;

  typedef struct packed {
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic multiproc_rate_select;
    logic rx_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } spmz_scon_type;

  typedef struct packed {
    logic baud_double;
    logic frame_err_select;
  } spmz_rate_type;

endpackage : spmz_pkg

// File: rtl/spmz_serial_port.sv
// The Wishbone slave port is this design's own decision.
`include "spmz_consts.svh"

module spmz_serial_port (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Rate source
  input wire logic timer1_ovf_i,
  // Serial pins
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o
);

  spmz_pkg::spmz_scon_type scon_r;
  spmz_pkg::spmz_rate_type rate_r;
  spmz_pkg::spmz_m0_state_type m0_state_r;
  spmz_pkg::spmz_atx_state_type atx_state_r;
  spmz_pkg::spmz_arx_state_type arx_state_r;
  logic fe_r;
  logic [7:0] rx_buf_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] idx;
  logic req;
  logic wr_en;
  logic wr_ctrl;
  logic wr_rate;
  logic buf_wr;
  logic mode0;
  logic nine;
  logic [1:0] div_cnt_r;
  logic ovf_half_r;
  logic [1:0] m2_last;
  logic tick16;
  logic [2:0] m0_hcnt_r;
  logic [2:0] m0_half;
  logic m0_clk_r;
  logic [2:0] m0_bit_r;
  logic [7:0] m0_sh_r;
  logic m0_step;
  logic m0_tx_done;
  logic m0_rx_done;
  logic ren_prev_r;
  logic m0_rx_go;
  logic [9:0] atx_sh_r;
  logic [3:0] atx_left_r;
  logic [3:0] atx_tick_r;
  logic tx_line_r;
  logic atx_done;
  logic rxd_prev_r;
  logic [3:0] arx_tick_r;
  logic [3:0] arx_cnt_r;
  logic [7:0] arx_sh_r;
  logic arx_sample;
  logic arx_accept;
  logic arx_fe;

  function automatic logic accept_ok(input logic ri, input logic sel, input logic bit9);
    accept_ok = !ri && (!sel || bit9);
  endfunction : accept_ok

  function automatic logic [7:0] reg_read(input logic [7:0] index);
    logic [7:0] v;
    v = `SPMZ_RST_BYTE;
    if (index == `SPMZ_IDX_RATE_CTRL) begin
      v[`SPMZ_BIT_BAUD_DOUBLE] = rate_r.baud_double;
      v[`SPMZ_BIT_FRAME_ERR_SEL] = rate_r.frame_err_select;
    end else if (index == `SPMZ_IDX_SER_CTRL) begin
      v = scon_r;
      v[`SPMZ_BIT_MODE_HI] = rate_r.frame_err_select ? fe_r : scon_r.mode_sel_hi;
    end else if (index == `SPMZ_IDX_SER_BUF) begin
      v = rx_buf_r;
    end
    reg_read = v;
  endfunction : reg_read

  // Bus: ack one cycle after the request, dropped the cycle after
  assign idx = adr_i[9:2];
  assign req = cyc_i && stb_i;
  assign wr_en = req && we_i && ack_r && sel_i[0];
  assign wr_ctrl = wr_en && (idx == `SPMZ_IDX_SER_CTRL);
  assign wr_rate = wr_en && (idx == `SPMZ_IDX_RATE_CTRL);
  assign buf_wr = wr_en && (idx == `SPMZ_IDX_SER_BUF);
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) begin
        dat_r <= {24'h000000, reg_read(idx)};
      end
    end
  end

  assign mode0 = !scon_r.mode_sel_hi && !scon_r.mode_sel_lo;
  assign nine = scon_r.mode_sel_hi;

  // Sixteen ticks per bit for the asynchronous modes
  assign m2_last = rate_r.baud_double ? 2'(`SPMZ_M2_DIV / `SPMZ_OVERSAMPLE / 2 - 1)
                                      : 2'(`SPMZ_M2_DIV / `SPMZ_OVERSAMPLE - 1);
  assign tick16 = scon_r.mode_sel_lo ? (timer1_ovf_i && (rate_r.baud_double || ovf_half_r))
                                     : (div_cnt_r == m2_last);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_r <= 2'h0;
      ovf_half_r <= 1'b0;
    end else begin
      div_cnt_r <= (div_cnt_r == m2_last) ? 2'h0 : div_cnt_r + 2'h1;
      if (timer1_ovf_i) begin
        ovf_half_r <= !ovf_half_r;
      end
    end
  end

  // Control registers; a hardware set wins over a software clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scon_r <= spmz_pkg::spmz_scon_type'(`SPMZ_RST_BYTE);
      fe_r <= 1'b0;
      rate_r <= spmz_pkg::spmz_rate_type'(2'h0);
    end else begin
      if (wr_rate) begin
        rate_r.baud_double <= dat_i[`SPMZ_BIT_BAUD_DOUBLE];
        rate_r.frame_err_select <= dat_i[`SPMZ_BIT_FRAME_ERR_SEL];
      end
      if (wr_ctrl) begin
        if (!rate_r.frame_err_select) begin
          scon_r.mode_sel_hi <= dat_i[`SPMZ_BIT_MODE_HI];
        end
        scon_r.mode_sel_lo <= dat_i[`SPMZ_BIT_MODE_LO];
        scon_r.multiproc_rate_select <= dat_i[`SPMZ_BIT_MP_RATE];
        scon_r.rx_enable <= dat_i[`SPMZ_BIT_RX_EN];
        scon_r.transmit_ninth_bit <= dat_i[`SPMZ_BIT_TX_NINTH];
      end
      if (arx_fe) begin
        fe_r <= 1'b1;
      end else if (wr_ctrl && rate_r.frame_err_select) begin
        fe_r <= dat_i[`SPMZ_BIT_MODE_HI];
      end
      if (m0_tx_done || atx_done) begin
        scon_r.transmit_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        scon_r.transmit_done_flag <= dat_i[`SPMZ_BIT_TX_DONE];
      end
      if (m0_rx_done || arx_accept) begin
        scon_r.receive_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        scon_r.receive_done_flag <= dat_i[`SPMZ_BIT_RX_DONE];
      end
      if (arx_accept) begin
        scon_r.received_ninth_bit <= rxd_i;
      end else if (wr_ctrl) begin
        scon_r.received_ninth_bit <= dat_i[`SPMZ_BIT_RX_NINTH];
      end
    end
  end

  // Receive register; transmit bytes go straight into the shifters
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_buf_r <= `SPMZ_RST_BYTE;
    end else begin
      if (m0_rx_done) begin
        rx_buf_r <= m0_sh_r;
      end else if (arx_accept) begin
        rx_buf_r <= arx_sh_r;
      end
    end
  end

  // Mode 0 shifter: this end always makes the shift clock
  assign m0_half = scon_r.multiproc_rate_select ? 3'(`SPMZ_M0_DIV_FAST / 2)
                                                : 3'(`SPMZ_M0_DIV_SLOW / 2);
  assign m0_step = (m0_state_r != spmz_pkg::M0_IDLE) && (m0_hcnt_r == m0_half - 3'h1);
  assign m0_tx_done = m0_step && m0_clk_r && (m0_bit_r == 3'h7) && (m0_state_r == spmz_pkg::M0_TX);
  assign m0_rx_done = m0_step && m0_clk_r && (m0_bit_r == 3'h7) && (m0_state_r == spmz_pkg::M0_RX);
  assign m0_rx_go = mode0 && scon_r.rx_enable && !ren_prev_r && !scon_r.receive_done_flag;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ren_prev_r <= 1'b0;
    end else begin
      ren_prev_r <= scon_r.rx_enable;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      m0_state_r <= spmz_pkg::M0_IDLE;
      m0_hcnt_r <= 3'h0;
      m0_clk_r <= 1'b1;
      m0_bit_r <= 3'h0;
      m0_sh_r <= 8'h00;
    end else begin
      case (m0_state_r)
        spmz_pkg::M0_IDLE: begin
          m0_hcnt_r <= 3'h0;
          m0_bit_r <= 3'h0;
          if (buf_wr && mode0) begin
            m0_state_r <= spmz_pkg::M0_TX;
            m0_sh_r <= dat_i[7:0];
            m0_clk_r <= 1'b0;
          end else if (m0_rx_go) begin
            m0_state_r <= spmz_pkg::M0_RX;
            m0_clk_r <= 1'b0;
          end
        end
        default: begin
          m0_hcnt_r <= m0_step ? 3'h0 : m0_hcnt_r + 3'h1;
          if (m0_step && !m0_clk_r) begin
            m0_clk_r <= 1'b1;
            if (m0_state_r == spmz_pkg::M0_RX) begin
              m0_sh_r <= {rxd_i, m0_sh_r[7:1]};
            end
          end else if (m0_step) begin
            if (m0_bit_r == 3'h7) begin
              m0_state_r <= spmz_pkg::M0_IDLE;
            end else begin
              m0_clk_r <= 1'b0;
              m0_bit_r <= m0_bit_r + 3'h1;
              if (m0_state_r == spmz_pkg::M0_TX) begin
                m0_sh_r <= {1'b0, m0_sh_r[7:1]};
              end
            end
          end
        end
      endcase
    end
  end

  assign rxd_o = m0_sh_r[0];
  assign rxd_oe_o = (m0_state_r == spmz_pkg::M0_TX);
  assign txd_o = mode0 ? m0_clk_r : tx_line_r;

  // Asynchronous transmitter; writes while busy are ignored and reload nothing
  assign atx_done = (atx_state_r == spmz_pkg::ATX_SEND) && tick16 && (atx_tick_r == 4'(`SPMZ_LAST_TICK))
                    && (atx_left_r == 4'h1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      atx_state_r <= spmz_pkg::ATX_IDLE;
      atx_sh_r <= 10'h3FF;
      atx_left_r <= 4'h0;
      atx_tick_r <= 4'h0;
      tx_line_r <= 1'b1;
    end else begin
      case (atx_state_r)
        spmz_pkg::ATX_IDLE: begin
          tx_line_r <= 1'b1;
          if (buf_wr && !mode0) begin
            atx_state_r <= spmz_pkg::ATX_SEND;
            tx_line_r <= 1'b0;
            atx_sh_r <= {1'b1, nine ? scon_r.transmit_ninth_bit : 1'b1, dat_i[7:0]};
            atx_left_r <= nine ? 4'hA : 4'h9;
            atx_tick_r <= 4'h0;
          end
        end
        default: begin
          if (tick16) begin
            atx_tick_r <= atx_tick_r + 4'h1;
            if (atx_tick_r == 4'(`SPMZ_LAST_TICK)) begin
              if (atx_left_r == 4'h0) begin
                atx_state_r <= spmz_pkg::ATX_IDLE;
                tx_line_r <= 1'b1;
              end else begin
                tx_line_r <= atx_sh_r[0];
                atx_sh_r <= {1'b1, atx_sh_r[9:1]};
                atx_left_r <= atx_left_r - 4'h1;
              end
            end
          end
        end
      endcase
    end
  end

  // Asynchronous receiver
  assign arx_sample = (arx_state_r == spmz_pkg::ARX_BITS) && tick16 && (arx_tick_r == 4'(`SPMZ_LAST_TICK));
  assign arx_accept = arx_sample && (arx_cnt_r == 4'h8)
                      && accept_ok(scon_r.receive_done_flag, scon_r.multiproc_rate_select, rxd_i);
  assign arx_fe = arx_sample && !rxd_i && (arx_cnt_r == (nine ? 4'h9 : 4'h8));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_prev_r <= rxd_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arx_state_r <= spmz_pkg::ARX_IDLE;
      arx_tick_r <= 4'h0;
      arx_cnt_r <= 4'h0;
      arx_sh_r <= 8'h00;
    end else begin
      case (arx_state_r)
        spmz_pkg::ARX_IDLE: begin
          arx_tick_r <= 4'h0;
          arx_cnt_r <= 4'h0;
          if (!mode0 && scon_r.rx_enable && rxd_prev_r && !rxd_i) begin
            arx_state_r <= spmz_pkg::ARX_START;
          end
        end
        spmz_pkg::ARX_START: begin
          if (tick16) begin
            arx_tick_r <= arx_tick_r + 4'h1;
            if (arx_tick_r == 4'(`SPMZ_MID_TICK)) begin
              arx_tick_r <= 4'h0;
              arx_state_r <= rxd_i ? spmz_pkg::ARX_IDLE : spmz_pkg::ARX_BITS;
            end
          end
        end
        default: begin
          if (tick16) begin
            arx_tick_r <= arx_tick_r + 4'h1;
          end
          if (arx_sample) begin
            arx_cnt_r <= arx_cnt_r + 4'h1;
            if (arx_cnt_r < 4'h8) begin
              arx_sh_r <= {rxd_i, arx_sh_r[7:1]};
            end
            if (arx_cnt_r == (nine ? 4'h9 : 4'h8)) begin
              arx_state_r <= spmz_pkg::ARX_IDLE;
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  m0_fast_clock_a: assert property (
    $rose(m0_clk_r) && scon_r.multiproc_rate_select && (m0_state_r != spmz_pkg::M0_IDLE) && (m0_bit_r != 3'h7)
    |-> m0_clk_r [*2] ##1 !m0_clk_r)
    else $error("mode 0 fast shift clock high phase wrong");
  m0_tx_flag_a: assert property (
    m0_tx_done |=> scon_r.transmit_done_flag && (m0_state_r == spmz_pkg::M0_IDLE))
    else $error("mode 0 transmit end did not set done flag");
  m0_rx_start_a: assert property (
    (m0_state_r == spmz_pkg::M0_IDLE) && m0_rx_go && !buf_wr |=> (m0_state_r == spmz_pkg::M0_RX))
    else $error("mode 0 receive did not start");
  m0_drive_a: assert property (
    (m0_state_r == spmz_pkg::M0_TX) && mode0
    |-> rxd_oe_o && (txd_o == m0_clk_r) && (!m0_clk_r || $stable(rxd_o)))
    else $error("mode 0 transmit pins not driven");
  atx_start_a: assert property (
    (atx_state_r == spmz_pkg::ATX_IDLE) && buf_wr && !mode0 |=> !txd_o && (atx_state_r == spmz_pkg::ATX_SEND))
    else $error("start bit not sent after buffer write");
  atx_done_a: assert property (
    atx_done |=> scon_r.transmit_done_flag && txd_o)
    else $error("done flag not set with stop bit");
  fast_tick_a: assert property (
    !scon_r.mode_sel_lo && rate_r.baud_double && tick16 ##1 !scon_r.mode_sel_lo && rate_r.baud_double
    ##1 !scon_r.mode_sel_lo && rate_r.baud_double |-> tick16 && !$past(tick16))
    else $error("doubled fixed rate tick spacing wrong");
  rx_glitch_a: assert property (
    (arx_state_r == spmz_pkg::ARX_START) && tick16 && (arx_tick_r == 4'(`SPMZ_MID_TICK)) && rxd_i
    |=> (arx_state_r == spmz_pkg::ARX_IDLE))
    else $error("glitch start not rejected");
  rx_reject_a: assert property (
    arx_sample && (arx_cnt_r == 4'h8) && scon_r.receive_done_flag |=> $stable(rx_buf_r))
    else $error("buffer loaded while done flag set");
  rx_accept_a: assert property (
    arx_accept |=> scon_r.receive_done_flag && (rx_buf_r == $past(arx_sh_r))
    && (scon_r.received_ninth_bit == $past(rxd_i)))
    else $error("accepted frame not loaded");
  fe_sticky_a: assert property (
    fe_r && !(wr_ctrl && rate_r.frame_err_select) |=> fe_r)
    else $error("frame error flag lost");

  m0_tx_cov: cover property (m0_tx_done);
  m0_rx_cov: cover property (m0_rx_done);
  rx_accept_cov: cover property (arx_accept && nine);
  rx_glitch_cov: cover property ((arx_state_r == spmz_pkg::ARX_START) ##1 (arx_state_r == spmz_pkg::ARX_IDLE));

endmodule : spmz_serial_port

// File: verification/spmz_serial_peer.sv
module spmz_serial_peer (
  // Device pins
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic data_i,
  input wire logic data_oe_i,
  // Peer drive
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic async_r = 1'b1;
  logic [7:0] m0_out = 8'h00;
  logic [7:0] m0_in = 8'h00;
  logic m0_on = 1'b0;
  int rises = 0;
  int idx = 0;
  time last_rise = 0;
  time period = 0;
  // Slave only: follows the device's shift clock, never makes one
  always @(posedge txd_i) begin
    period = $time - last_rise;
    last_rise = $time;
    rises++;
    if (data_oe_i) m0_in = {data_i, m0_in[7:1]};
  end
  // Next bit goes out on the falling shift clock
  always @(negedge txd_i) idx = rises;
  // Past the last bit the line shows garbage, not a held value
  assign line_o = m0_on ? (idx < 8 ? m0_out[idx[2:0]] : ~m0_out[7]) : async_r;
  task m0_load(input logic [7:0] b, input logic on);
    m0_out = b;
    m0_in = 8'h00;
    m0_on = on;
    rises = 0;
    idx = 0;
  endtask : m0_load
  // Frame lsb first, start bit in f[0], idle high after
  task send(input logic [10:0] f, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      async_r <= f[i];
      repeat (len) @(posedge clk_i);
    end
    async_r <= 1'b1;
  endtask : send
  // Data bit 0 must be 1: the start bit is partial, its end marks the grid
  task recv(input int n, input int len, output logic [10:0] f);
    int k;
    f = 11'h000;
    k = 0;
    while (txd_i !== 1'b0 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    f[0] = txd_i;
    k = 0;
    while (txd_i !== 1'b1 && k < len) begin
      @(posedge clk_i);
      k++;
    end
    repeat (len / 2) @(posedge clk_i);
    for (int i = 1; i < n; i++) begin
      f[i] = txd_i;
      if (i < n - 1) repeat (len) @(posedge clk_i);
    end
  endtask : recv
endmodule : spmz_serial_peer

// File: verification/tb_top.sv
`include "spmz_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] A_RATE = {`SPMZ_IDX_RATE_CTRL, 2'b00};
  localparam logic [9:0] A_CTRL = {`SPMZ_IDX_SER_CTRL, 2'b00};
  localparam logic [9:0] A_BUF = {`SPMZ_IDX_SER_BUF, 2'b00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ovf = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [10:0] fr;
  logic [1:0] tdiv = 2'h0;
  logic ack, dd, doe, txd, pline, rxd;
  int fails = 0;
  int comparisons = 0;

  always #10 clk = ~clk;
  // Overflow every third clock so timer modes differ from the fixed rate
  always @(posedge clk) begin
    tdiv <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
    ovf <= (tdiv == 2'h2);
  end
  assign rxd = doe ? dd : pline;

  spmz_serial_port dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .timer1_ovf_i(ovf), .rxd_i(rxd),
    .rxd_o(dd), .rxd_oe_o(doe), .txd_o(txd));
  spmz_serial_peer peer (.clk_i(clk), .txd_i(txd), .data_i(dd), .data_oe_i(doe), .line_o(pline));

  task close_out;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) begin
      fails++;
      close_out();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task rd(input logic [9:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask : rd

  task wait_ctrl(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      wb(1'b0, A_CTRL, 8'h00);
      n++;
    end while ((q[7:0] & m) !== m && n < 400);
    if (n >= 400) begin
      fails++;
      close_out();
    end
  endtask : wait_ctrl

  task t_regs;
    rd(A_CTRL, 8'h00);
    rd(A_BUF, 8'h00);
    rd(10'h000, 8'h00);
    sel <= 4'h0;
    wb(1'b1, A_RATE, 8'hFF);
    sel <= 4'h1;
    rd(A_RATE, 8'h00);
    wb(1'b1, A_RATE, 8'hFF);
    rd(A_RATE, 8'hC0);
    wb(1'b1, A_RATE, 8'h00);
    $display("regs done");
  endtask : t_regs

  task t_m0_tx(input logic mp, input int per);
    peer.m0_load(8'h00, 1'b0);
    wb(1'b1, A_CTRL, {2'b00, mp, 5'h00});
    wb(1'b1, A_BUF, 8'hA5);
    wait_ctrl(8'h02);
    chk({24'h000000, peer.m0_in}, 32'h000000A5);
    chk(32'(peer.period), per);
    chk({31'h0, doe}, 32'h00000000);
    $display("mode 0 transmit done");
  endtask : t_m0_tx

  task t_m0_rx(input logic [7:0] b);
    peer.m0_load(b, 1'b1);
    wb(1'b1, A_CTRL, 8'h20);
    wb(1'b1, A_CTRL, 8'h30);
    wait_ctrl(8'h01);
    rd(A_BUF, b);
    rd(A_CTRL, 8'h31);
    peer.m0_load(8'h00, 1'b0);
    $display("mode 0 receive done");
  endtask : t_m0_rx

  // Enable toggled while the done flag stands must not start a byte
  task t_m0_block;
    peer.m0_load(8'hFF, 1'b1);
    wb(1'b1, A_CTRL, 8'h21);
    wb(1'b1, A_CTRL, 8'h31);
    repeat (200) @(posedge clk);
    chk(32'(peer.rises), 32'h00000000);
    rd(A_BUF, 8'h6C);
    $display("mode 0 blocked trigger done");
  endtask : t_m0_block

  task t_atx(input logic [7:0] rate, input logic [7:0] ctrl, input logic [7:0] d, input int n, input int len,
      input logic [10:0] e);
    wb(1'b1, A_RATE, rate);
    wb(1'b1, A_CTRL, ctrl);
    wb(1'b1, A_BUF, d);
    peer.recv(n, len, fr);
    chk({21'h0, fr}, {21'h0, e});
    rd(A_CTRL, ctrl | 8'h02);
    repeat (len) @(posedge clk);
    $display("async transmit done");
  endtask : t_atx

  task t_arx(input logic [10:0] f, input int n, input int len, input logic [7:0] eb, input logic [7:0] ec);
    peer.send(f, n, len);
    repeat (8) @(posedge clk);
    rd(A_BUF, eb);
    rd(A_CTRL, ec);
    $display("async receive done");
  endtask : t_arx

  task cfg(input logic [7:0] rate, input logic [7:0] ctrl);
    wb(1'b1, A_RATE, rate);
    wb(1'b1, A_CTRL, ctrl);
  endtask : cfg

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_m0_tx(1'b0, 240);
    t_m0_tx(1'b1, 80);
    t_m0_rx(8'h6C);
    t_m0_block();
    t_m0_rx(8'h93);
    t_atx(8'h00, 8'h88, 8'h35, 11, 64, {2'b11, 8'h35, 1'b0});
    t_atx(8'h80, 8'h80, 8'hC3, 11, 32, {2'b10, 8'hC3, 1'b0});
    t_atx(8'h00, 8'h40, 8'h5B, 10, 96, {2'b01, 8'h5B, 1'b0});
    t_atx(8'h80, 8'h40, 8'h99, 10, 48, {2'b01, 8'h99, 1'b0});
    cfg(8'h00, 8'h50);
    t_arx({2'b01, 8'hE7, 1'b0}, 10, 96, 8'hE7, 8'h55);
    cfg(8'h00, 8'h51);
    t_arx({2'b01, 8'h12, 1'b0}, 10, 96, 8'hE7, 8'h51);
    cfg(8'h40, 8'h70);
    t_arx({2'b00, 8'h42, 1'b0}, 10, 96, 8'hE7, 8'hF0);
    cfg(8'h00, 8'h90);
    t_arx({2'b10, 8'h3A, 1'b0}, 11, 64, 8'h3A, 8'h91);
    cfg(8'h00, 8'hB0);
    t_arx({2'b10, 8'h44, 1'b0}, 11, 64, 8'h3A, 8'hB0);
    cfg(8'h80, 8'hB0);
    t_arx({2'b11, 8'h6E, 1'b0}, 11, 32, 8'h6E, 8'hB5);
    cfg(8'h00, 8'h90);
    // Short low pulse, then a frame one bit later that a false start would shift
    peer.send(11'h002, 2, 4);
    repeat (60) @(posedge clk);
    t_arx({2'b10, 8'h2D, 1'b0}, 11, 64, 8'h2D, 8'h91);
    close_out();
  end
endmodule : tb_top
